// *** verilog/cpm_pin_mux.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cpm_defines.svh"
// Contract
// - port G pins reset as GPIO inputs
// - port G fields pick progressive/interlace pixel data
// - port F pins 4-7 reset as inputs
// - F bits 9:8 route camera vsync
// - F bits 11:10 route camera hsync
// - F bits 13:12 clock out or field
// - F bits 15:14 route pixel clock
// - H pin0 card enable2 or SD data0
// - H pin1 card enable1 or SD data1
// - H pin2 IO read or SD data2
// - H pin3 IO write or SD data3
// - H pin4 card wait or SD command
// - H pin5 card reset or SD clock
// - card reset high holds card reset
// - H pin6 card irq or SD detect
// - H pin7 status change or write protect
// - I pin0 buffer enable or SD output
// - I pin1 function1 is bus direction
// - bus direction low while reading card
// - H and I pins reset as inputs
// - port A function1 carries two UARTs
// - A pins 2,3 function2 audio WS, SCK
// - A pins 6,7 function2 I2C lines
module cpm_pin_mux (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// pads; port_f bit n is pin n+4
	input wire logic [7:0] port_a_in,
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe,
	input wire logic [3:0] port_f_in,
	output logic [3:0] port_f_out,
	output logic [3:0] port_f_oe,
	input wire logic [7:0] port_g_in,
	output logic [7:0] port_g_out,
	output logic [7:0] port_g_oe,
	input wire logic [7:0] port_h_in,
	output logic [7:0] port_h_out,
	output logic [7:0] port_h_oe,
	input wire logic [1:0] port_i_in,
	output logic [1:0] port_i_out,
	output logic [1:0] port_i_oe,
	// second camera
	output logic [7:0] cam2_prog_pixel_data,
	output logic [7:0] cam2_intl_pixel_data,
	output logic cam2_prog_vsync,
	output logic cam2_intl_vsync,
	output logic cam2_prog_hsync,
	output logic cam2_intl_hsync,
	output logic cam2_field_id,
	output logic cam2_prog_pixel_clock,
	output logic cam2_intl_pixel_clock,
	input wire logic cam2_base_clock_out,
	// card interface
	input wire logic card_enable2_n,
	input wire logic card_enable1_n,
	input wire logic card_io_read_n,
	input wire logic card_io_write_n,
	input wire logic card_reset_out,
	input wire logic card_buffer_enable_n,
	input wire logic card_bus_direction,
	output logic card_wait_n,
	output logic card_irq_in,
	output logic card_status_change_n,
	// sd card
	input wire logic [3:0] sdcard_data_line_out,
	input wire logic [3:0] sdcard_data_line_oe,
	output logic [3:0] sdcard_data_line_in,
	input wire logic sdcard_command_line_out,
	input wire logic sdcard_command_line_oe,
	output logic sdcard_command_line_in,
	input wire logic sdcard_clock_out,
	input wire logic sdcard_general_output,
	output logic sdcard_detect_n,
	output logic sdcard_write_protect,
	// uarts, audio, i2c
	input wire logic uart_first_tx,
	input wire logic uart_first_rts,
	output logic uart_first_rx,
	output logic uart_first_cts,
	input wire logic uart_second_tx,
	input wire logic uart_second_rts,
	output logic uart_second_rx,
	output logic uart_second_cts,
	input wire logic audio_second_word_select,
	input wire logic audio_second_serial_clock,
	input wire logic i2c_scl_pull_low,
	input wire logic i2c_sda_pull_low,
	output logic i2c_scl_level,
	output logic i2c_sda_level
);
	// --------------------------------
	// helpers
	// --------------------------------
	// pick pad drive {oe,out} from the field code
	function automatic logic [1:0] pad_pick(input logic [1:0] fs, input logic [1:0] g,
		input logic [1:0] a, input logic [1:0] b);
		logic [1:0] r;
		r = g;
		unique case (fs)
			cpm_pkg::cpm_fn_one: r = a;
			cpm_pkg::cpm_fn_two: r = b;
			cpm_pkg::cpm_fn_gpio, cpm_pkg::cpm_fn_rsv: r = g;
		endcase
		return r;
	endfunction
	// true when pin k of a select word holds code c
	function automatic logic is_fn(input logic [15:0] w, input int k, input logic [1:0] c);
		return w[`CPM_FSEL_W*k +: `CPM_FSEL_W] == c;
	endfunction
	// pins that exist on each port
	function automatic logic [7:0] pin_mask(input int p);
		if (p == `CPM_PF)
			return `CPM_PIN_MASK_F;
		if (p == `CPM_PI)
			return `CPM_PIN_MASK_I;
		return `CPM_PIN_MASK_FULL;
	endfunction
	// byte-lane merge for 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] o, input logic [15:0] n, input logic [1:0] s);
		return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
	endfunction
	// --------------------------------
	// state
	// --------------------------------
	cpm_pkg::cpm_wr_state_t wr_state_q, wr_state_d;
	cpm_pkg::cpm_rd_state_t rd_state_q, rd_state_d;
	logic aw_got_q, aw_got_d, w_got_q, w_got_d; // channel taken, waiting for partner
	logic [7:0] waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [15:0] fsel_q [`CPM_NPORTS]; // per-port function select
	logic [15:0] fsel_d [`CPM_NPORTS];
	logic [15:0] gpio_q [`CPM_NPORTS]; // {oe, out} per port
	logic [15:0] gpio_d [`CPM_NPORTS];
	logic [7:0] pin_in [`CPM_NPORTS]; // pads in 8-pin space
	logic [7:0] pad_out_q [`CPM_NPORTS];
	logic [7:0] pad_out_d [`CPM_NPORTS];
	logic [7:0] pad_oe_q [`CPM_NPORTS];
	logic [7:0] pad_oe_d [`CPM_NPORTS];
	logic [1:0] f1 [`CPM_NPORTS][8]; // function 1 {oe,out}
	logic [1:0] f2 [`CPM_NPORTS][8]; // function 2 {oe,out}
	logic [31:0] core_q, core_d; // packed core-side inputs
	logic [7:0] cpd_q, cpd_d, cid_q, cid_d;
	logic hit_w, hit_r;

	// pads into one indexable view
	always_comb begin
		pin_in[`CPM_PA] = port_a_in;
		pin_in[`CPM_PF] = {port_f_in, 4'h0};
		pin_in[`CPM_PG] = port_g_in;
		pin_in[`CPM_PH] = port_h_in;
		pin_in[`CPM_PI] = {6'h00, port_i_in};
	end

	// --------------------------------
	// axi4-lite slave and registers
	// --------------------------------
	// aw and w may arrive in either order; the write lands once both are in
	always_comb begin
		wr_state_d = wr_state_q;
		rd_state_d = rd_state_q;
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		awready_d = awready_q;
		wready_d = wready_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		hit_w = 1'b0;
		hit_r = 1'b0;
		fsel_d = fsel_q;
		gpio_d = gpio_q;
		unique case (wr_state_q)
			cpm_pkg::cpm_wr_idle: begin
				if (awvalid && awready_q) begin
					aw_got_d = 1'b1;
					waddr_d = awaddr;
				end
				if (wvalid && wready_q) begin
					w_got_d = 1'b1;
					wdata_d = wdata;
					wstrb_d = wstrb;
				end
				awready_d = !aw_got_d;
				wready_d = !w_got_d;
				if (aw_got_d && w_got_d) begin
					for (int p = 0; p < `CPM_NPORTS; p++) begin
						// port I select bits and gpio bits of absent pins stay zero; port F select keeps all 16 bits
						if ({waddr_d[7:2], 2'b00} == 8'(`CPM_OFS_FSEL_BASE + `CPM_REG_STRIDE * p)) begin
							hit_w = 1'b1;
							fsel_d[p] = merge16(fsel_q[p], wdata_d[15:0], wstrb_d[1:0])
								& ((p == `CPM_PI) ? `CPM_FSEL_MASK_I : `CPM_FSEL_MASK_FULL);
						end
						if ({waddr_d[7:2], 2'b00} == 8'(`CPM_OFS_GPIO_BASE + `CPM_REG_STRIDE * p)) begin
							hit_w = 1'b1;
							gpio_d[p] = merge16(gpio_q[p], wdata_d[15:0], wstrb_d[1:0]) & {2{pin_mask(p)}};
						end
					end
					bresp_d = hit_w ? `CPM_RESP_OKAY : `CPM_RESP_SLVERR;
					bvalid_d = 1'b1;
					aw_got_d = 1'b0;
					w_got_d = 1'b0;
					awready_d = 1'b0;
					wready_d = 1'b0;
					wr_state_d = cpm_pkg::cpm_wr_resp;
				end
			end
			cpm_pkg::cpm_wr_resp: begin
				// both readies stay low so no second write starts early
				if (bready) begin
					bvalid_d = 1'b0;
					awready_d = 1'b1;
					wready_d = 1'b1;
					wr_state_d = cpm_pkg::cpm_wr_idle;
				end
			end
		endcase
		unique case (rd_state_q)
			cpm_pkg::cpm_rd_idle: begin
				arready_d = 1'b1;
				if (arvalid && arready_q) begin
					rdata_d = 32'h0000_0000;
					for (int p = 0; p < `CPM_NPORTS; p++) begin
						if ({araddr[7:2], 2'b00} == 8'(`CPM_OFS_FSEL_BASE + `CPM_REG_STRIDE * p)) begin
							hit_r = 1'b1;
							rdata_d = {16'h0000, fsel_q[p]};
						end
						if ({araddr[7:2], 2'b00} == 8'(`CPM_OFS_GPIO_BASE + `CPM_REG_STRIDE * p)) begin
							hit_r = 1'b1;
							rdata_d = {8'h00, pin_in[p] & pin_mask(p), gpio_q[p]};
						end
					end
					rresp_d = hit_r ? `CPM_RESP_OKAY : `CPM_RESP_SLVERR;
					rvalid_d = 1'b1;
					arready_d = 1'b0;
					rd_state_d = cpm_pkg::cpm_rd_data;
				end
			end
			cpm_pkg::cpm_rd_data: begin
				if (rready) begin
					rvalid_d = 1'b0;
					arready_d = 1'b1;
					rd_state_d = cpm_pkg::cpm_rd_idle;
				end
			end
		endcase
	end

	// bus and register flops; every select field clears to gpio
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= cpm_pkg::cpm_wr_idle;
			rd_state_q <= cpm_pkg::cpm_rd_idle;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `CPM_RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `CPM_RESP_OKAY;
			for (int p = 0; p < `CPM_NPORTS; p++) begin
				fsel_q[p] <= `CPM_FSEL_RST;
				gpio_q[p] <= `CPM_GPIO_RST;
			end
		end else begin
			wr_state_q <= wr_state_d;
			rd_state_q <= rd_state_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			fsel_q <= fsel_d;
			gpio_q <= gpio_d;
		end
	end

	// --------------------------------
	// pad drive mux
	// --------------------------------
	// undefined functions fall back to gpio, so a stray code never floats a pin
	always_comb begin
		for (int p = 0; p < `CPM_NPORTS; p++) begin
			for (int k = 0; k < 8; k++) begin
				f1[p][k] = {gpio_q[p][`CPM_GPIO_OE_LSB + k], gpio_q[p][`CPM_GPIO_OUT_LSB + k]};
				f2[p][k] = f1[p][k];
			end
		end
		f1[`CPM_PA][0] = {1'b1, uart_first_tx};
		f1[`CPM_PA][1] = 2'b00;
		f1[`CPM_PA][2] = {1'b1, uart_first_rts};
		f1[`CPM_PA][3] = 2'b00;
		f1[`CPM_PA][4] = {1'b1, uart_second_tx};
		f1[`CPM_PA][5] = 2'b00;
		f1[`CPM_PA][6] = {1'b1, uart_second_rts};
		f1[`CPM_PA][7] = 2'b00;
		f2[`CPM_PA][2] = {1'b1, audio_second_word_select};
		f2[`CPM_PA][3] = {1'b1, audio_second_serial_clock};
		f2[`CPM_PA][6] = {i2c_scl_pull_low, 1'b0};
		f2[`CPM_PA][7] = {i2c_sda_pull_low, 1'b0};
		for (int k = 4; k < 8; k++) begin
			f1[`CPM_PF][k] = 2'b00;
			f2[`CPM_PF][k] = 2'b00;
		end
		f1[`CPM_PF][6] = {1'b1, cam2_base_clock_out};
		for (int k = 0; k < 8; k++) begin
			f1[`CPM_PG][k] = 2'b00;
			f2[`CPM_PG][k] = 2'b00;
		end
		f1[`CPM_PH][0] = {1'b1, card_enable2_n};
		f1[`CPM_PH][1] = {1'b1, card_enable1_n};
		f1[`CPM_PH][2] = {1'b1, card_io_read_n};
		f1[`CPM_PH][3] = {1'b1, card_io_write_n};
		f1[`CPM_PH][4] = 2'b00;
		f1[`CPM_PH][5] = {1'b1, card_reset_out};
		f1[`CPM_PH][6] = 2'b00;
		f1[`CPM_PH][7] = 2'b00;
		for (int k = 0; k < 4; k++)
			f2[`CPM_PH][k] = {sdcard_data_line_oe[k], sdcard_data_line_out[k]};
		f2[`CPM_PH][4] = {sdcard_command_line_oe, sdcard_command_line_out};
		f2[`CPM_PH][5] = {1'b1, sdcard_clock_out};
		f2[`CPM_PH][6] = 2'b00;
		f2[`CPM_PH][7] = 2'b00;
		f1[`CPM_PI][0] = {1'b1, card_buffer_enable_n};
		f2[`CPM_PI][0] = {1'b1, sdcard_general_output};
		f1[`CPM_PI][1] = {1'b1, card_bus_direction};
		for (int p = 0; p < `CPM_NPORTS; p++) begin
			for (int k = 0; k < 8; k++) begin
				{pad_oe_d[p][k], pad_out_d[p][k]} = pad_pick(fsel_q[p][`CPM_FSEL_W*k +: `CPM_FSEL_W],
					f1[p][k] & {2{1'b0}} | {gpio_q[p][`CPM_GPIO_OE_LSB + k], gpio_q[p][`CPM_GPIO_OUT_LSB + k]},
					f1[p][k], f2[p][k]) & {2{|(pin_mask(p) & (8'h01 << k))}};
			end
		end
	end

	// --------------------------------
	// core-side receive mux
	// --------------------------------
	// unselected inputs park at their idle level: active-low ones high
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			cpd_d[k] = is_fn(fsel_q[`CPM_PG], k, cpm_pkg::cpm_fn_one) & pin_in[`CPM_PG][k];
			cid_d[k] = is_fn(fsel_q[`CPM_PG], k, cpm_pkg::cpm_fn_two) & pin_in[`CPM_PG][k];
		end
		core_d = 32'h0000_0000;
		core_d[0] = is_fn(fsel_q[`CPM_PF], 4, cpm_pkg::cpm_fn_one) & pin_in[`CPM_PF][4];
		core_d[1] = is_fn(fsel_q[`CPM_PF], 4, cpm_pkg::cpm_fn_two) & pin_in[`CPM_PF][4];
		core_d[2] = is_fn(fsel_q[`CPM_PF], 5, cpm_pkg::cpm_fn_one) & pin_in[`CPM_PF][5];
		core_d[3] = is_fn(fsel_q[`CPM_PF], 5, cpm_pkg::cpm_fn_two) & pin_in[`CPM_PF][5];
		core_d[4] = is_fn(fsel_q[`CPM_PF], 6, cpm_pkg::cpm_fn_two) & pin_in[`CPM_PF][6];
		core_d[5] = is_fn(fsel_q[`CPM_PF], 7, cpm_pkg::cpm_fn_one) & pin_in[`CPM_PF][7];
		core_d[6] = is_fn(fsel_q[`CPM_PF], 7, cpm_pkg::cpm_fn_two) & pin_in[`CPM_PF][7];
		core_d[7] = is_fn(fsel_q[`CPM_PH], 4, cpm_pkg::cpm_fn_one) ? pin_in[`CPM_PH][4] : 1'b1;
		core_d[8] = is_fn(fsel_q[`CPM_PH], 6, cpm_pkg::cpm_fn_one) & pin_in[`CPM_PH][6];
		core_d[9] = is_fn(fsel_q[`CPM_PH], 7, cpm_pkg::cpm_fn_one) ? pin_in[`CPM_PH][7] : 1'b1;
		for (int k = 0; k < 4; k++)
			core_d[10 + k] = is_fn(fsel_q[`CPM_PH], k, cpm_pkg::cpm_fn_two) & pin_in[`CPM_PH][k];
		core_d[14] = is_fn(fsel_q[`CPM_PH], 4, cpm_pkg::cpm_fn_two) & pin_in[`CPM_PH][4];
		core_d[15] = is_fn(fsel_q[`CPM_PH], 6, cpm_pkg::cpm_fn_two) ? pin_in[`CPM_PH][6] : 1'b1;
		core_d[16] = is_fn(fsel_q[`CPM_PH], 7, cpm_pkg::cpm_fn_two) & pin_in[`CPM_PH][7];
		core_d[17] = is_fn(fsel_q[`CPM_PA], 1, cpm_pkg::cpm_fn_one) ? pin_in[`CPM_PA][1] : 1'b1;
		core_d[18] = is_fn(fsel_q[`CPM_PA], 3, cpm_pkg::cpm_fn_one) ? pin_in[`CPM_PA][3] : 1'b1;
		core_d[19] = is_fn(fsel_q[`CPM_PA], 5, cpm_pkg::cpm_fn_one) ? pin_in[`CPM_PA][5] : 1'b1;
		core_d[20] = is_fn(fsel_q[`CPM_PA], 7, cpm_pkg::cpm_fn_one) ? pin_in[`CPM_PA][7] : 1'b1;
		core_d[21] = is_fn(fsel_q[`CPM_PA], 6, cpm_pkg::cpm_fn_two) ? pin_in[`CPM_PA][6] : 1'b1;
		core_d[22] = is_fn(fsel_q[`CPM_PA], 7, cpm_pkg::cpm_fn_two) ? pin_in[`CPM_PA][7] : 1'b1;
	end

	// pad and core flops; pads come up as inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int p = 0; p < `CPM_NPORTS; p++) begin
				pad_out_q[p] <= 8'h00;
				pad_oe_q[p] <= 8'h00;
			end
			cpd_q <= 8'h00;
			cid_q <= 8'h00;
			core_q <= 32'h007e_8280; // idle levels: wait, status, detect, rx, cts, i2c high
		end else begin
			pad_out_q <= pad_out_d;
			pad_oe_q <= pad_oe_d;
			cpd_q <= cpd_d;
			cid_q <= cid_d;
			core_q <= core_d;
		end
	end

	// --------------------------------
	// outputs
	// --------------------------------
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign port_a_out = pad_out_q[`CPM_PA];
	assign port_a_oe = pad_oe_q[`CPM_PA];
	assign port_f_out = pad_out_q[`CPM_PF][7:4];
	assign port_f_oe = pad_oe_q[`CPM_PF][7:4];
	assign port_g_out = pad_out_q[`CPM_PG];
	assign port_g_oe = pad_oe_q[`CPM_PG];
	assign port_h_out = pad_out_q[`CPM_PH];
	assign port_h_oe = pad_oe_q[`CPM_PH];
	assign port_i_out = pad_out_q[`CPM_PI][1:0];
	assign port_i_oe = pad_oe_q[`CPM_PI][1:0];
	assign cam2_prog_pixel_data = cpd_q;
	assign cam2_intl_pixel_data = cid_q;
	assign cam2_prog_vsync = core_q[0];
	assign cam2_intl_vsync = core_q[1];
	assign cam2_prog_hsync = core_q[2];
	assign cam2_intl_hsync = core_q[3];
	assign cam2_field_id = core_q[4];
	assign cam2_prog_pixel_clock = core_q[5];
	assign cam2_intl_pixel_clock = core_q[6];
	assign card_wait_n = core_q[7];
	assign card_irq_in = core_q[8];
	assign card_status_change_n = core_q[9];
	assign sdcard_data_line_in = core_q[13:10];
	assign sdcard_command_line_in = core_q[14];
	assign sdcard_detect_n = core_q[15];
	assign sdcard_write_protect = core_q[16];
	assign uart_first_rx = core_q[17];
	assign uart_first_cts = core_q[18];
	assign uart_second_rx = core_q[19];
	assign uart_second_cts = core_q[20];
	assign i2c_scl_level = core_q[21];
	assign i2c_sda_level = core_q[22];

	// --------------------------------
	// assertions
	// --------------------------------
	sequence s_rd_taken;
		arvalid && arready;
	endsequence
	sequence s_rd_held;
		rvalid && !rready;
	endsequence
	property p_reset_inputs;
		@(posedge aclk) disable iff (!aresetn) $rose(aresetn) |-> port_g_oe == 8'h00 && port_f_oe == 4'h0
			&& port_h_oe == 8'h00 && port_i_oe == 2'b00;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("pads not inputs after reset");
	property p_g_prog;
		@(posedge aclk) disable iff (!aresetn) fsel_q[`CPM_PG] == 16'h5555 |=> cam2_prog_pixel_data == $past(port_g_in)
			&& cam2_intl_pixel_data == 8'h00 && port_g_oe == 8'h00;
	endproperty
	a_g_prog: assert property (p_g_prog) else $error("camera data not routed");
	property p_f_vsync;
		@(posedge aclk) disable iff (!aresetn) fsel_q[`CPM_PF][9:8] == 2'b10 |=> cam2_intl_vsync == $past(port_f_in[0])
			&& !cam2_prog_vsync;
	endproperty
	a_f_vsync: assert property (p_f_vsync) else $error("interlace vsync not routed");
	property p_f_clk;
		@(posedge aclk) disable iff (!aresetn) fsel_q[`CPM_PF][13:12] == 2'b01 |=> port_f_oe[2]
			&& port_f_out[2] == $past(cam2_base_clock_out);
	endproperty
	a_f_clk: assert property (p_f_clk) else $error("camera clock not driven");
	property p_h_ce2;
		@(posedge aclk) disable iff (!aresetn) fsel_q[`CPM_PH][1:0] == 2'b01 |=> port_h_oe[0]
			&& port_h_out[0] == $past(card_enable2_n);
	endproperty
	a_h_ce2: assert property (p_h_ce2) else $error("card enable not driven");
	property p_h_cmd;
		@(posedge aclk) disable iff (!aresetn) fsel_q[`CPM_PH][9:8] == 2'b10 |=> port_h_oe[4] == $past(sdcard_command_line_oe)
			&& sdcard_command_line_in == $past(port_h_in[4]);
	endproperty
	a_h_cmd: assert property (p_h_cmd) else $error("sd command not routed");
	property p_h_rst;
		@(posedge aclk) disable iff (!aresetn) fsel_q[`CPM_PH][11:10] == 2'b01 |=> port_h_out[5] == $past(card_reset_out);
	endproperty
	a_h_rst: assert property (p_h_rst) else $error("card reset level wrong");
	property p_i_dir;
		@(posedge aclk) disable iff (!aresetn) fsel_q[`CPM_PI][3:2] == 2'b01 |=> port_i_oe[1]
			&& port_i_out[1] == $past(card_bus_direction);
	endproperty
	a_i_dir: assert property (p_i_dir) else $error("direction not driven");
	property p_a_scl;
		@(posedge aclk) disable iff (!aresetn) fsel_q[`CPM_PA][13:12] == 2'b10 |=> !port_a_out[6]
			&& port_a_oe[6] == $past(i2c_scl_pull_low);
	endproperty
	a_a_scl: assert property (p_a_scl) else $error("scl not open drain");
	property p_rsv_gpio;
		@(posedge aclk) disable iff (!aresetn) fsel_q[`CPM_PH][15:14] == 2'b11 |=> port_h_oe[7] == $past(gpio_q[`CPM_PH][15]);
	endproperty
	a_rsv_gpio: assert property (p_rsv_gpio) else $error("reserved code not gpio");
	property p_rd_answer;
		@(posedge aclk) disable iff (!aresetn) s_rd_taken |=> rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer lost");
	// a stalled answer must keep its data until the master takes it
	property p_rd_hold;
		@(posedge aclk) disable iff (!aresetn) s_rd_held |=> rvalid && $stable(rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
endmodule
`default_nettype wire

// *** pkg/cpm_defines.svh ***
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH
// ------------------------------
// port indices
// ------------------------------
`define CPM_PA 0
`define CPM_PF 1
`define CPM_PG 2
`define CPM_PH 3
`define CPM_PI 4
`define CPM_NPORTS 5
// ------------------------------
// register map
// ------------------------------
`define CPM_OFS_FSEL_BASE 8'h00
`define CPM_OFS_GPIO_BASE 8'h20
`define CPM_REG_STRIDE 4
`define CPM_FSEL_RST 16'h0000
`define CPM_GPIO_RST 16'h0000
`define CPM_GPIO_OUT_LSB 0
`define CPM_GPIO_OE_LSB 8
`define CPM_GPIO_IN_LSB 16
`define CPM_FSEL_W 2
// ------------------------------
// implemented pins and fields
// ------------------------------
`define CPM_PIN_MASK_FULL 8'hff
`define CPM_PIN_MASK_F 8'hf0
`define CPM_PIN_MASK_I 8'h03
`define CPM_FSEL_MASK_FULL 16'hffff
`define CPM_FSEL_MASK_I 16'h000f
// ------------------------------
// bus answers
// ------------------------------
`define CPM_RESP_OKAY 2'b00
`define CPM_RESP_SLVERR 2'b10
`endif

// *** pkg/cpm_pkg.sv ***
package cpm_pkg;
	// per-pin selection code
	typedef enum logic [1:0] {
		cpm_fn_gpio = 2'b00,
		cpm_fn_one = 2'b01,
		cpm_fn_two = 2'b10,
		cpm_fn_rsv = 2'b11
	} cpm_fsel_t;
	// write channel state
	typedef enum logic [1:0] {
		cpm_wr_idle = 2'b01,
		cpm_wr_resp = 2'b10
	} cpm_wr_state_t;
	// read channel state
	typedef enum logic [1:0] {
		cpm_rd_idle = 2'b01,
		cpm_rd_data = 2'b10
	} cpm_rd_state_t;
endpackage

// *** dv/cpm_pad_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// far side: camera, card and uart parts drive every pin the device leaves undriven
// ------------------------------
module cpm_pad_model (
	// level the far parts put on released pins
	input wire logic [7:0] pat,
	// device pad drive
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_a_oe,
	input wire logic [3:0] port_f_out,
	input wire logic [3:0] port_f_oe,
	input wire logic [7:0] port_g_out,
	input wire logic [7:0] port_g_oe,
	input wire logic [7:0] port_h_out,
	input wire logic [7:0] port_h_oe,
	input wire logic [1:0] port_i_out,
	input wire logic [1:0] port_i_oe,
	// resolved pin levels
	output logic [7:0] port_a_in,
	output logic [3:0] port_f_in,
	output logic [7:0] port_g_in,
	output logic [7:0] port_h_in,
	output logic [1:0] port_i_in
);
	// a driving device wins; a far part only drives where the device has let go
	assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & pat);
	assign port_f_in = (port_f_oe & port_f_out) | (~port_f_oe & pat[3:0]);
	assign port_g_in = (port_g_oe & port_g_out) | (~port_g_oe & pat);
	assign port_h_in = (port_h_oe & port_h_out) | (~port_h_oe & pat);
	assign port_i_in = (port_i_oe & port_i_out) | (~port_i_oe & pat[1:0]);
endmodule
`default_nettype wire

// *** dv/cpm_pin_mux_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpm_pin_mux_test;
	// ------------------------------
	// bench signals, named as the ports so .* can join them
	// ------------------------------
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0, pat = 8'h00;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 4'hf, sdcard_data_line_out = 0, sdcard_data_line_oe = 0;
	logic [2:0] awprot = 0, arprot = 0;
	logic cam2_base_clock_out = 1, card_enable2_n = 0, card_enable1_n = 0, card_io_read_n = 0;
	logic card_io_write_n = 0, card_reset_out = 1, card_buffer_enable_n = 1, card_bus_direction = 0;
	logic sdcard_command_line_out = 0, sdcard_command_line_oe = 0, sdcard_clock_out = 0, sdcard_general_output = 0;
	logic uart_first_tx = 1, uart_first_rts = 0, uart_second_tx = 0, uart_second_rts = 0;
	logic audio_second_word_select = 0, audio_second_serial_clock = 0, i2c_scl_pull_low = 0, i2c_sda_pull_low = 0;
	logic awready, wready, bvalid, arready, rvalid, cam2_prog_vsync, cam2_intl_vsync, cam2_prog_hsync;
	logic cam2_intl_hsync, cam2_field_id, cam2_prog_pixel_clock, cam2_intl_pixel_clock, card_wait_n, card_irq_in;
	logic card_status_change_n, sdcard_command_line_in, sdcard_detect_n, sdcard_write_protect, uart_first_rx;
	logic uart_first_cts, uart_second_rx, uart_second_cts, i2c_scl_level, i2c_sda_level;
	logic [1:0] bresp, rresp, port_i_in, port_i_out, port_i_oe;
	logic [31:0] rdata;
	logic [7:0] port_a_in, port_a_out, port_a_oe, port_g_in, port_g_out, port_g_oe, port_h_in, port_h_out, port_h_oe;
	logic [7:0] cam2_prog_pixel_data, cam2_intl_pixel_data;
	logic [3:0] port_f_in, port_f_out, port_f_oe, sdcard_data_line_in;
	int num_errors = 0, n_compared = 0, cyc = 0;
	// rows: address, write data, expected read back
	logic [71:0] rows [8] = '{{8'h00, 32'hffff, 32'hffff}, {8'h04, 32'h1234, 32'h1234}, {8'h08, 32'hffffffff, 32'hffff},
		{8'h0c, 32'he5c3, 32'he5c3}, {8'h10, 32'hffff, 32'h000f}, {8'h08, 32'h0, 32'h0},
		{8'h28, 32'hff3c, 32'h003cff3c}, {8'h28, 32'h0, 32'h0}};
	cpm_pin_mux uut (.*);
	cpm_pad_model far (.*);
	// clock at 200 MHz; the timeout ends a hang as a mismatch
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc > 4000) begin
			num_errors++;
			results();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h, wanted %h", $time, g, e);
		end
	endtask
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!(bvalid && bready));
		bready <= 0;
		chk(bresp, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (!(rvalid && rready));
		rready <= 0;
		chk({rresp, rdata}, {er, e});
	endtask
	// a new select reaches the pads and the core side one cycle after the answer
	task automatic sel(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, 2'b00);
		repeat (4) @(posedge aclk);
	endtask
	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk({port_g_oe, port_h_oe, port_f_oe, port_i_oe}, 0);
		rd(8'h0c, 0, 2'b00);
		foreach (rows[i]) begin
			wr(rows[i][71:64], rows[i][63:32], 2'b00);
			rd(rows[i][71:64], rows[i][31:0], 2'b00);
		end
		$display("register table done");
		wr(8'hfc, 32'h1, 2'b10);
		rd(8'hfc, 0, 2'b10);
		pat <= 8'ha5;
		sel(8'h08, 32'h5555);
		chk({cam2_prog_pixel_data, cam2_intl_pixel_data}, 16'ha500);
		sel(8'h08, 32'haaaa);
		chk({cam2_prog_pixel_data, cam2_intl_pixel_data}, 16'h00a5);
		sel(8'h08, 32'hffff);
		chk({port_g_oe, cam2_prog_pixel_data, cam2_intl_pixel_data}, 0);
		sel(8'h04, 32'h5500);
		chk({port_f_oe, port_f_out[2], cam2_prog_pixel_clock, cam2_prog_hsync, cam2_prog_vsync}, 8'h49);
		sel(8'h04, 32'haa00);
		chk({port_f_oe, cam2_intl_pixel_clock, cam2_field_id, cam2_intl_hsync, cam2_intl_vsync}, 8'h05);
		$display("camera done");
		sel(8'h0c, 32'h5555);
		chk({port_h_oe, port_h_out & port_h_oe, card_wait_n, card_irq_in, card_status_change_n}, 19'h17901);
		card_reset_out <= 0;
		repeat (2) @(posedge aclk);
		chk(port_h_out[5], 0);
		sel(8'h0c, 32'haaaa);
		chk({port_h_oe[7:4], sdcard_command_line_in, sdcard_detect_n, sdcard_write_protect, sdcard_data_line_in}, 11'h115);
		sel(8'h10, 32'h0005);
		chk({port_i_oe, port_i_out}, 4'hd);
		$display("card done");
		sel(8'h00, 32'h5555);
		chk({port_a_oe, port_a_out[0], uart_first_rx, uart_second_cts}, 11'h2ad);
		sel(8'h00, 32'ha0a0);
		chk({port_a_oe, i2c_scl_level, i2c_sda_level}, 10'h031);
		i2c_scl_pull_low <= 1;
		repeat (2) @(posedge aclk);
		chk({port_a_oe[6], port_a_out[6]}, 2'b10);
		$display("uart done");
		// mid-run reset: ports A, H, I and F pads back to input, port A select back to gpio
		aresetn <= 0;
		@(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk({port_a_oe, port_h_oe, port_i_oe, port_f_oe}, 0);
		rd(8'h00, 0, 2'b00);
		$display("reset done");
		results();
	end
endmodule
`default_nettype wire
